// file: include/chain_shifter_consts.vh
// Constants for the daisy-chain command shifter
`ifndef CHAIN_SHIFTER_CONSTS_VH
`define CHAIN_SHIFTER_CONSTS_VH
`define WORD_BITS 16
`define INSTR_CMD_HI 15
`define INSTR_CMD_LO 13
`define INSTR_TARGET_BIT 8
`define DATA_HI 7
`define DATA_LO 0
`define CMD_NOP 3'h0
`define CMD_SHUTDOWN 3'h1
`define CMD_WRITE 3'h2
`define GAIN_RESET 8'h00
`define CHAN_RESET 8'h00
`endif

// file: rtl/edge_sync.v
// Two-flop synchroniser with edge detection for one pin
`timescale 1ns/1ns
`default_nettype none
module edge_sync (
  input wire clk_i,   // System clock
  input wire rst_i,   // Async reset, high
  input wire pin_i,   // Asynchronous pin
  input wire init_i,  // Reset level of the pin
  output wire level_o, // Synchronised level
  output wire rise_o, // One-cycle rising edge
  output wire fall_o  // One-cycle falling edge
);
  reg meta_reg;
  reg sync_reg;
  reg last_reg;
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= pin_i ^ init_i;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end
  assign level_o = sync_reg ^ init_i;
  assign rise_o = level_o & ~(last_reg ^ init_i);
  assign fall_o = ~level_o & (last_reg ^ init_i);
endmodule // edge_sync
`default_nettype wire

// file: rtl/spi_chain_shifter.v
// SPI daisy-chain command shift path of the gain amplifier
`timescale 1ns/1ns
`default_nettype none
`include "chain_shifter_consts.vh"
module spi_chain_shifter #(
  parameter WORD_BITS = `WORD_BITS
) (
  input wire CLK_SYS_I,      // System clock, 10 MHz
  input wire RST_I,          // Async reset, high
  input wire SCK_I,          // Serial clock pin
  input wire CS_N_I,         // Chip select pin, low active
  input wire SI_I,           // Serial data in
  output wire SO_O,          // Serial data out
  output wire SO_OE_O,       // Serial out drive enable
  output wire [7:0] GAIN_O,  // Gain register
  output wire [7:0] CHAN_O,  // Channel register
  output wire SHUTDOWN_O     // Shutdown state
);
  wire sck_lvl;
  wire sck_rise;
  wire sck_fall;
  wire cs_lvl;
  wire cs_rise;
  wire cs_fall;
  reg si_meta_reg;
  reg si_sync_reg;
  reg [WORD_BITS-1:0] shift_reg;
  // Counter wraps once per word, so word widths up to 256 bits keep the check exact
  localparam CNT_BITS = 8;
  localparam integer LAST_INT = WORD_BITS - 1;
  localparam [CNT_BITS-1:0] LAST_BIT = LAST_INT[CNT_BITS-1:0];
  reg [CNT_BITS-1:0] bit_cnt_reg;
  reg idle_hi_reg;
  reg so_reg;
  reg active_reg;
  reg [7:0] gain_reg;
  reg [7:0] chan_reg;
  reg shdn_reg;
  wire [2:0] cmd;
  wire target_sel;
  wire [7:0] data_byte;
  wire shift_now;
  wire out_now;
  wire exec_now;

  function is_write;
    input [2:0] code;
    begin
      is_write = (code == `CMD_WRITE);
    end
  endfunction

  edge_sync u_sck (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .pin_i(SCK_I),
    .init_i(1'b0),
    .level_o(sck_lvl),
    .rise_o(sck_rise),
    .fall_o(sck_fall)
  );

  edge_sync u_cs (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .pin_i(CS_N_I),
    .init_i(1'b1),
    .level_o(cs_lvl),
    .rise_o(cs_rise),
    .fall_o(cs_fall)
  );

  always @(posedge CLK_SYS_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      si_meta_reg <= 1'b0;
      si_sync_reg <= 1'b0;
    end
    else
    begin
      si_meta_reg <= SI_I;
      si_sync_reg <= si_meta_reg;
    end
  end

  // Mode 1,1 idles clock high: first falling edge does not update SO
  assign shift_now = active_reg & sck_rise;
  assign out_now = active_reg & sck_fall & ~idle_hi_reg;
  // Execute only whole words, all devices together
  assign exec_now = cs_rise & active_reg & (bit_cnt_reg == {CNT_BITS{1'b0}});

  assign cmd = shift_reg[`INSTR_CMD_HI:`INSTR_CMD_LO];
  assign target_sel = shift_reg[`INSTR_TARGET_BIT];
  assign data_byte = shift_reg[`DATA_HI:`DATA_LO];

  // Frame control: select state, bit count, idle clock level
  always @(posedge CLK_SYS_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      active_reg <= 1'b0;
      idle_hi_reg <= 1'b0;
      bit_cnt_reg <= {CNT_BITS{1'b0}};
    end
    else if (cs_fall)
    begin
      active_reg <= 1'b1;
      idle_hi_reg <= sck_lvl;
      bit_cnt_reg <= {CNT_BITS{1'b0}};
    end
    else if (cs_rise)
    begin
      active_reg <= 1'b0;
    end
    else
    begin
      if (shift_now)
      begin
        if (bit_cnt_reg == LAST_BIT)
          bit_cnt_reg <= {CNT_BITS{1'b0}};
        else
          bit_cnt_reg <= bit_cnt_reg + 1'b1;
      end
      if (sck_fall)
        idle_hi_reg <= 1'b0;
    end
  end

  // Shifter: MSB first; cleared shifter yields sixteen zeros out
  always @(posedge CLK_SYS_I or posedge RST_I)
  begin
    if (RST_I)
      shift_reg <= {WORD_BITS{1'b0}};
    else if (cs_rise)
      shift_reg <= {WORD_BITS{1'b0}};
    else if (shift_now && !cs_fall)
      shift_reg <= {shift_reg[WORD_BITS-2:0], si_sync_reg};
  end

  // Serial output stage
  always @(posedge CLK_SYS_I or posedge RST_I)
  begin
    if (RST_I)
      so_reg <= 1'b0;
    else if (cs_fall || cs_rise)
      so_reg <= 1'b0;
    else if (out_now)
      so_reg <= shift_reg[WORD_BITS-1];
  end

  always @(posedge CLK_SYS_I or posedge RST_I)
  begin
    if (RST_I)
      gain_reg <= `GAIN_RESET;
    else if (exec_now && is_write(cmd) && !target_sel)
      gain_reg <= data_byte;
  end

  always @(posedge CLK_SYS_I or posedge RST_I)
  begin
    if (RST_I)
      chan_reg <= `CHAN_RESET;
    else if (exec_now && is_write(cmd) && target_sel)
      chan_reg <= data_byte;
  end

  // Shutdown: set by its command, left by any write
  always @(posedge CLK_SYS_I or posedge RST_I)
  begin
    if (RST_I)
      shdn_reg <= 1'b0;
    else if (exec_now)
    begin
      case (cmd)
        `CMD_NOP:
          shdn_reg <= shdn_reg;
        `CMD_SHUTDOWN:
          shdn_reg <= 1'b1;
        `CMD_WRITE:
          shdn_reg <= 1'b0;
        default:
          shdn_reg <= shdn_reg;
      endcase
    end
  end


  assign SO_O = so_reg;
  assign SO_OE_O = active_reg;
  assign GAIN_O = gain_reg;
  assign CHAN_O = chan_reg;
  assign SHUTDOWN_O = shdn_reg;
endmodule // spi_chain_shifter
`default_nettype wire

// file: testbench/chain_props.sv
// Port assertions, chain shifter
`timescale 1ns/1ns
`default_nettype none
module chain_props (
  input wire logic CLK_SYS_I, RST_I, SCK_I, CS_N_I, SI_I, SO_O, SO_OE_O, SHUTDOWN_O, // Pins
  input wire logic [7:0] GAIN_O, CHAN_O // Registers
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  property p_on; $fell(CS_N_I) |-> ##[2:5] SO_OE_O; endproperty
  a_on: assert property (p_on) else $error("oe late");
  property p_off; $rose(CS_N_I) |-> ##[2:5] !SO_OE_O; endproperty
  a_off: assert property (p_off) else $error("oe stuck");
  property p_z; $rose(SO_OE_O) |-> !SO_O; endproperty
  a_z: assert property (p_z) else $error("so set");
  property p_hold; !CS_N_I [*5] |-> $stable({GAIN_O, CHAN_O, SHUTDOWN_O}); endproperty
  a_hold: assert property (p_hold) else $error("early");
  property p_upd; !$stable({GAIN_O, CHAN_O, SHUTDOWN_O}) |-> CS_N_I; endproperty
  a_upd: assert property (p_upd) else $error("update");
  property p_idle; CS_N_I [*6] |-> !SO_OE_O; endproperty
  a_idle: assert property (p_idle) else $error("oe idle");
  property p_so; !$stable(SO_O) && $past(SO_OE_O) && SO_OE_O |-> !$past(SCK_I, 2); endproperty
  a_so: assert property (p_so) else $error("so time");
  property p_sd; $rose(SHUTDOWN_O) |-> $stable({GAIN_O, CHAN_O}); endproperty
  a_sd: assert property (p_sd) else $error("sd regs");
endmodule // chain_props
bind spi_chain_shifter chain_props chk_u (.*);
`default_nettype wire

// file: testbench/spi_master_model.sv
// SPI master model driving the chain
`timescale 1ns/1ns
`default_nettype none
module spi_master_model (
  input wire logic clk_i, // System clock
  input wire logic so_i, // Chain output
  output logic sck_o = 1'b0, // Serial clock
  output logic cs_n_o = 1'b1, // Select, low active
  output logic si_o = 1'b0, // Serial data
  output logic [31:0] rx_o = 32'h0 // Bits seen on output
);
  task automatic frame(input logic [31:0] d, input int n, input logic m);
    @(posedge clk_i) sck_o <= m;
    @(posedge clk_i) cs_n_o <= 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      repeat (4) @(posedge clk_i);
      sck_o <= 1'b0;
      si_o <= d[i];
      repeat (4) @(posedge clk_i);
      sck_o <= 1'b1;
      rx_o <= {rx_o[30:0], so_i};
    end
    repeat (4) @(posedge clk_i);
    sck_o <= m;
    si_o <= ~si_o;
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b1;
    repeat (9) @(posedge clk_i);
  endtask
endmodule // spi_master_model
`default_nettype wire

// file: testbench/tb_top.sv
// Bench, chain shifter
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic CLK_SYS_I = 0, RST_I = 1, SCK_I, CS_N_I, SI_I, SO_O, SO_OE_O, SHUTDOWN_O;
  logic [7:0] GAIN_O, CHAN_O, G2, C2;
  logic SD2;
  logic [31:0] rx;
  int err_total = 0, total_checks = 0;
  spi_chain_shifter dut_u (.*);
  spi_chain_shifter far_u (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .SCK_I(SCK_I), .CS_N_I(CS_N_I),
    .SI_I(SO_O), .SO_O(), .SO_OE_O(), .GAIN_O(G2), .CHAN_O(C2), .SHUTDOWN_O(SD2));
  spi_master_model m_u (.clk_i(CLK_SYS_I), .so_i(SO_O), .sck_o(SCK_I), .cs_n_o(CS_N_I),
    .si_o(SI_I), .rx_o(rx));
  task automatic chk(string n, logic [31:0] e, v);
    total_checks++;
    if (v !== e)
    begin
      err_total++;
      $display("[ERR] %s exp %h got %h", n, e, v);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic t1;
    m_u.frame(32'h402a, 16, 1'b0);
    m_u.frame(32'h4101, 16, 1'b1);
    m_u.frame(32'hf_4055, 20, 1'b0);
    chk("g", 32'h2a, GAIN_O);
    chk("c", 32'h1, CHAN_O);
    chk("g2", 32'h0, G2);
    chk("oe", 32'h0, SO_OE_O);
    $display("t1 end");
  endtask
  task automatic t2;
    m_u.frame(32'h4033_0000, 32, 1'b0);
    chk("g", 32'h2a, GAIN_O);
    chk("g2", 32'h33, G2);
    chk("so", 32'h4033, rx);
    $display("t2 end");
  endtask
  task automatic t3;
    m_u.frame(32'h2000, 16, 1'b1);
    chk("sd", 32'h1, SHUTDOWN_O);
    chk("sd2", 32'h0, SD2);
    m_u.frame(32'h4100, 16, 1'b0);
    chk("sd", 32'h0, SHUTDOWN_O);
    chk("c", 32'h0, CHAN_O);
    $display("t3 end");
  endtask
  initial
    forever #50 CLK_SYS_I = ~CLK_SYS_I;
  initial
  begin
    repeat (4) @(posedge CLK_SYS_I);
    RST_I <= 1'b0;
    repeat (3) @(posedge CLK_SYS_I);
    t1;
    t2;
    t3;
    test_done;
  end
  initial
  begin
    repeat (9000) @(posedge CLK_SYS_I);
    err_total++;
    test_done;
  end
endmodule // tb_top
`default_nettype wire
